// *** pkg/t3_pkg.sv ***
/*
  Constants and types shared by the timer 3 design files.
  Assumes a byte-wide special function register port and one system clock.
*/
// Function
// - Split bytes count on system clock when own select is 1, else external select.
// - Split mode sets high overflow flag when high byte overflows from 0xFF and reloads.
// - Low overflow flag sets on every low byte wrap, whatever the mode.
// - With timer interrupts enabled, each high byte overflow requests an interrupt.
// - With low-byte enable also set, either byte overflow requests an interrupt.
// - Hardware never clears either overflow flag; only software writes clear them.
// - Capture enable bit set puts the 16-bit counter in period-capture mode.
// - Capture fires on comparator 1 rising edge or every 8 oscillator cycles.
// - Capture copies counter into reload pair and sets high overflow flag.
// - Select codes 00 and 01 trigger on comparator; 10 and 11 on oscillator/8.
// - Split bit 0 gives one 16-bit timer, 1 gives two 8-bit timers.
// - In 16-bit mode high flag sets when counter overflows from 0xFFFF and reloads.
// - External sources are synchronised to the system clock before use.
// - In 16-bit mode overflow loads the reload pair into the counter.
// - In split mode each byte reloads from its own reload byte on overflow.
// - Interrupt requests count only while the global timer enable is set.
package t3_pkg;
  typedef logic [7:0] t3_byte_t;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam t3_byte_t T3_CTRL_OFS = 8'h91;
  localparam t3_byte_t T3_RLL_OFS = 8'h92;
  localparam t3_byte_t T3_RLH_OFS = 8'h93;
  localparam t3_byte_t T3_CNTL_OFS = 8'h94;
  localparam t3_byte_t T3_CNTH_OFS = 8'h95;
  // ----------------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------------
  localparam int T3_HF_BIT = 7;
  localparam int T3_LF_BIT = 6;
  localparam int T3_LEN_BIT = 5;
  localparam int T3_CEN_BIT = 4;
  localparam int T3_SPLIT_BIT = 3;
  localparam int T3_RUN_BIT = 2;
  localparam int T3_XCLK_HI_BIT = 1;
  localparam int T3_XCLK_LO_BIT = 0;
  localparam t3_byte_t T3_CTRL_RST = 8'h00;
  localparam t3_byte_t T3_BYTE_RST = 8'h00;
  localparam t3_byte_t T3_BYTE_MAX = 8'hff;
  localparam logic [15:0] T3_WORD_MAX = 16'hffff;
  // ----------------------------------------------------------------------
  // External clock select codes and dividers
  // ----------------------------------------------------------------------
  localparam logic [1:0] T3_XCLK_EXT8 = 2'b01;
  localparam logic [1:0] T3_XCLK_CMP = 2'b11;
  localparam int T3_SYS_DIV = 12;
  localparam int T3_EXT_DIV = 8;
endpackage

// *** pkg/t3_tick_if.sv ***
/*
  Tick strobes passed from the source conditioner to the timer core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface t3_tick_if;
  logic div12_tick;
  logic ext8_tick;
  logic cmp_rise;
  modport gen (output div12_tick, output ext8_tick, output cmp_rise);
  modport use_side (input div12_tick, input ext8_tick, input cmp_rise);
endinterface
`default_nettype wire

// *** hw/t3_tick_gen.sv ***
/*
  Conditions the timer clock sources: system clock prescaler, external
  oscillator divider and comparator edge detector, all as one-cycle ticks.
  Assumes raw pins may change at any time relative to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module t3_tick_gen #(
  parameter int SYS_DIV = t3_pkg::T3_SYS_DIV,
  parameter int EXT_DIV = t3_pkg::T3_EXT_DIV
) (
  input wire logic clk,
  input wire logic rst_n_sync,
  input wire logic ext_osc_in,
  input wire logic comp1_in,
  t3_tick_if.gen ticks
);
  import t3_pkg::*;
  localparam int PW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);

  typedef struct packed {
    logic cmp_meta;
    logic cmp_sync;
    logic cmp_dly;
    logic osc_meta;
    logic osc_sync;
    logic osc_dly;
    logic [PW-1:0] pre;
    logic [EW-1:0] ext;
    logic div12;
    logic ext8;
    logic rise;
  } t3_gen_s;

  t3_gen_s gen_reg;
  t3_gen_s gen_next;

  // ----------------------------------------------------------------------
  // Source conditioning
  // ----------------------------------------------------------------------
  always_comb
  begin
    gen_next = gen_reg;
    // Two-stage synchronisers; only the second stage feeds edge logic.
    gen_next.cmp_meta = comp1_in;
    gen_next.cmp_sync = gen_reg.cmp_meta;
    gen_next.cmp_dly = gen_reg.cmp_sync;
    gen_next.osc_meta = ext_osc_in;
    gen_next.osc_sync = gen_reg.osc_meta;
    gen_next.osc_dly = gen_reg.osc_sync;
    gen_next.rise = gen_reg.cmp_sync & ~gen_reg.cmp_dly;
    gen_next.div12 = (gen_reg.pre == PW'(SYS_DIV - 1));
    gen_next.pre = gen_next.div12 ? '0 : gen_reg.pre + PW'(1);
    gen_next.ext8 = 1'b0;
    if (gen_reg.osc_sync & ~gen_reg.osc_dly)
    begin
      gen_next.ext8 = (gen_reg.ext == EW'(EXT_DIV - 1));
      gen_next.ext = gen_next.ext8 ? '0 : gen_reg.ext + EW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      gen_reg <= '0;
    else
      gen_reg <= gen_next;
  end

  assign ticks.div12_tick = gen_reg.div12;
  assign ticks.ext8_tick = gen_reg.ext8;
  assign ticks.cmp_rise = gen_reg.rise;
endmodule
`default_nettype wire

// *** hw/t3_timer.sv ***
/*
  Timer 3 core: 16-bit auto-reload, split 8-bit auto-reload and period
  capture modes, with the control, reload and counter byte registers.
  Assumes a synchronous byte-wide register port and that the clock-select
  bits and the global interrupt enable arrive as plain levels.
*/
`timescale 1ns/1ns
`default_nettype none
module t3_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire t3_pkg::t3_byte_t sfr_addr,
  input wire t3_pkg::t3_byte_t sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output t3_pkg::t3_byte_t sfr_rdata,
  input wire logic high_byte_clock_select,
  input wire logic low_byte_clock_select,
  input wire logic timer_irq_global_enable,
  input wire logic ext_osc_in,
  input wire logic comp1_in,
  output logic timer_irq
);
  import t3_pkg::*;

  typedef struct packed {
    t3_byte_t ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    t3_byte_t rdata;
    logic irq;
  } t3_state_s;

  t3_state_s state_reg;
  t3_state_s state_next;
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic tick_low;
  logic tick_high;
  logic cap_trig;
  logic high_set;
  logic low_set;

  t3_tick_if ticks ();

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  t3_tick_gen u_tick_gen (
    .clk(clk),
    .rst_n_sync(rst_sync_reg),
    .ext_osc_in(ext_osc_in),
    .comp1_in(comp1_in),
    .ticks(ticks)
  );

  // ----------------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------------
  // A select of 1 counts every system clock; otherwise the external select
  // field picks the shared source, so both bytes see the same external tick.
  function automatic logic pick_tick(
    input logic sys_sel,
    input logic [1:0] xclk,
    input logic div12,
    input logic ext8,
    input logic rise
  );
    logic t;
    t = div12;
    if (sys_sel)
      t = 1'b1;
    else if (xclk == T3_XCLK_EXT8)
      t = ext8;
    else if (xclk == T3_XCLK_CMP)
      t = rise;
    return t;
  endfunction

  always_comb
  begin
    tick_low = pick_tick(low_byte_clock_select,
      state_reg.ctrl[T3_XCLK_HI_BIT:T3_XCLK_LO_BIT], ticks.div12_tick,
      ticks.ext8_tick, ticks.cmp_rise);
    tick_high = pick_tick(high_byte_clock_select,
      state_reg.ctrl[T3_XCLK_HI_BIT:T3_XCLK_LO_BIT], ticks.div12_tick,
      ticks.ext8_tick, ticks.cmp_rise);
    cap_trig = state_reg.ctrl[T3_XCLK_HI_BIT] ? ticks.ext8_tick
      : ticks.cmp_rise;
  end

  // ----------------------------------------------------------------------
  // Counting, capture and register access
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    high_set = 1'b0;
    low_set = 1'b0;
    if (state_reg.ctrl[T3_CEN_BIT])
    begin
      // Capture mode runs the counter freely over all 16 bits.
      if (state_reg.ctrl[T3_RUN_BIT] && tick_low)
      begin
        state_next.count = state_reg.count + 16'h0001;
        low_set = (state_reg.count[7:0] == T3_BYTE_MAX);
        high_set = (state_reg.count == T3_WORD_MAX);
      end
      if (cap_trig)
      begin
        state_next.reload = state_reg.count;
        high_set = 1'b1;
      end
    end
    else if (!state_reg.ctrl[T3_SPLIT_BIT])
    begin
      if (state_reg.ctrl[T3_RUN_BIT] && tick_low)
      begin
        if (state_reg.count == T3_WORD_MAX)
        begin
          state_next.count = state_reg.reload;
          high_set = 1'b1;
          low_set = 1'b1;
        end
        else
        begin
          state_next.count = state_reg.count + 16'h0001;
          low_set = (state_reg.count[7:0] == T3_BYTE_MAX);
        end
      end
    end
    else
    begin
      // The low byte ignores the run bit in split mode.
      if (tick_low)
      begin
        if (state_reg.count[7:0] == T3_BYTE_MAX)
        begin
          state_next.count[7:0] = state_reg.reload[7:0];
          low_set = 1'b1;
        end
        else
          state_next.count[7:0] = state_reg.count[7:0] + 8'h01;
      end
      if (state_reg.ctrl[T3_RUN_BIT] && tick_high)
      begin
        if (state_reg.count[15:8] == T3_BYTE_MAX)
        begin
          state_next.count[15:8] = state_reg.reload[15:8];
          high_set = 1'b1;
        end
        else
          state_next.count[15:8] = state_reg.count[15:8] + 8'h01;
      end
    end
    // A software write to a data byte overrides the same-cycle count.
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        T3_CTRL_OFS: state_next.ctrl = sfr_wdata;
        T3_RLL_OFS: state_next.reload[7:0] = sfr_wdata;
        T3_RLH_OFS: state_next.reload[15:8] = sfr_wdata;
        T3_CNTL_OFS: state_next.count[7:0] = sfr_wdata;
        T3_CNTH_OFS: state_next.count[15:8] = sfr_wdata;
        default: ;
      endcase
    end
    // Flags are only ever set here; clearing is left to software.
    state_next.ctrl[T3_HF_BIT] = state_next.ctrl[T3_HF_BIT] | high_set;
    state_next.ctrl[T3_LF_BIT] = state_next.ctrl[T3_LF_BIT] | low_set;
    state_next.irq = timer_irq_global_enable
      & (state_reg.ctrl[T3_HF_BIT]
      | (state_reg.ctrl[T3_LEN_BIT] & state_reg.ctrl[T3_LF_BIT]));
    state_next.rdata = T3_BYTE_RST;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        T3_CTRL_OFS: state_next.rdata = state_reg.ctrl;
        T3_RLL_OFS: state_next.rdata = state_reg.reload[7:0];
        T3_RLH_OFS: state_next.rdata = state_reg.reload[15:8];
        T3_CNTL_OFS: state_next.rdata = state_reg.count[7:0];
        T3_CNTH_OFS: state_next.rdata = state_reg.count[15:8];
        default: state_next.rdata = T3_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      state_reg.ctrl <= T3_CTRL_RST;
      state_reg.reload <= {T3_BYTE_RST, T3_BYTE_RST};
      state_reg.count <= {T3_BYTE_RST, T3_BYTE_RST};
      state_reg.rdata <= T3_BYTE_RST;
      state_reg.irq <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  assign sfr_rdata = state_reg.rdata;
  assign timer_irq = state_reg.irq;
endmodule
`default_nettype wire

// *** verification/t3_timer_asserts.sv ***
/*
  Checker for the timer 3 register port and interrupt line.
  Assumes it is bound to t3_timer and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module t3_timer_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire t3_pkg::t3_byte_t sfr_addr,
  input wire t3_pkg::t3_byte_t sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire t3_pkg::t3_byte_t sfr_rdata,
  input wire logic timer_irq_global_enable,
  input wire logic timer_irq
);
  import t3_pkg::*;
  logic rd_ctrl;
  assign rd_ctrl = sfr_rd && !sfr_wr && sfr_addr == T3_CTRL_OFS;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_rd_idle;
    !$past(sfr_rd) |-> sfr_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped;
    sfr_rd && (sfr_addr < T3_CTRL_OFS || sfr_addr > T3_CNTH_OFS)
      |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_ctrl_back;
    sfr_wr && sfr_addr == T3_CTRL_OFS ##1 !sfr_wr ##1 rd_ctrl
      |=> (sfr_rdata & 8'h3f) == ($past(sfr_wdata, 3) & 8'h3f);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control bits");
  property p_irq_en;
    !$past(timer_irq_global_enable) |-> !timer_irq;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  property p_irq_flags;
    rd_ctrl && timer_irq_global_enable
      |=> timer_irq == (sfr_rdata[7] | (sfr_rdata[5] & sfr_rdata[6]));
  endproperty
  a_irq_flags: assert property (p_irq_flags) else $error("irq vs flags");
  property p_irq_hold;
    timer_irq && timer_irq_global_enable && !$past(sfr_wr) |=> timer_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_irq_fall;
    $fell(timer_irq) |-> $past(sfr_wr, 2) || !$past(timer_irq_global_enable);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_flag_keep;
    rd_ctrl ##1 (sfr_rdata[7] && !sfr_wr) ##1 rd_ctrl |=> sfr_rdata[7];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag cleared");
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
/*
  Self-checking bench for t3_timer driven through its register port.
  Assumes the design files and t3_pkg are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import t3_pkg::*;
  logic clk, rstn, wr, rd, hsel, lsel, gen, osc, cmp, irq;
  t3_byte_t addr, wdata, rdata, r1, r2, lo_e, hi_e;
  int failures, check_count, cycles;
  t3_timer dut_u (.clk(clk), .rstn(rstn), .sfr_addr(addr),
    .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata),
    .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
    .timer_irq_global_enable(gen), .ext_osc_in(osc), .comp1_in(cmp),
    .timer_irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The limit is far above the roughly 1100 cycles the tests need.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("ERROR cycle limit expected %0d seen %0d", 0, cycles);
      end_of_test();
    end
  end
  task automatic chk(input string nm, input t3_byte_t e, input t3_byte_t g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input t3_byte_t lo, hi, g);
    if (g >= lo && g <= hi)
      chk(nm, g, g);
    else
      chk(nm, lo, g);
  endtask
  task automatic wr_reg(input t3_byte_t a, input t3_byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input t3_byte_t a, output t3_byte_t d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic rd_chk(input string nm, input t3_byte_t a, input t3_byte_t e);
    t3_byte_t d;
    rd_reg(a, d);
    chk(nm, e, d);
  endtask
  initial
  begin
    {rstn, wr, rd, hsel, lsel, gen, osc, cmp} = '0;
    {addr, wdata, failures, check_count, cycles} = '0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    for (int a = 8'h90; a <= 8'h96; a++)
      rd_chk("reset value", 8'(a), 8'h00);
    wr_reg(T3_CTRL_OFS, 8'h3f);
    rd_chk("control", T3_CTRL_OFS, 8'h3f);
    wr_reg(T3_CTRL_OFS, 8'h00);
    $display("test registers done");
    {gen, lsel, hsel} = 3'b111;
    wr_reg(T3_RLL_OFS, 8'h34);
    wr_reg(T3_RLH_OFS, 8'h12);
    wr_reg(T3_CNTL_OFS, 8'hfe);
    wr_reg(T3_CNTH_OFS, 8'hff);
    wr_reg(T3_CTRL_OFS, 8'h04);
    repeat (6) @(negedge clk);
    // Run stays on, so any flag read below was set by the wrap.
    rd_chk("reloaded high", T3_CNTH_OFS, 8'h12);
    rd_chk("wrap flags", T3_CTRL_OFS, 8'hc4);
    chk("irq", 8'h01, {7'h00, irq});
    gen = 1'b0;
    repeat (2) @(negedge clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    repeat (20) @(negedge clk);
    rd_chk("flags kept", T3_CTRL_OFS, 8'hc4);
    rd_chk("flags reread", T3_CTRL_OFS, 8'hc4);
    gen = 1'b1;
    wr_reg(T3_CTRL_OFS, 8'h00);
    rd_chk("flags cleared", T3_CTRL_OFS, 8'h00);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("test wide mode done");
    wr_reg(T3_RLL_OFS, 8'h80);
    wr_reg(T3_CNTL_OFS, 8'hfe);
    wr_reg(T3_CNTH_OFS, 8'hff);
    wr_reg(T3_CTRL_OFS, 8'h08);
    repeat (4) @(negedge clk);
    rd_chk("high stopped", T3_CNTH_OFS, 8'hff);
    rd_chk("low flag only", T3_CTRL_OFS, 8'h48);
    chk("no low irq", 8'h00, {7'h00, irq});
    rd_reg(T3_CNTL_OFS, r1);
    chk_rng("low reload", 8'h80, 8'h90, r1);
    wr_reg(T3_CTRL_OFS, 8'h68);
    repeat (2) @(negedge clk);
    chk("low irq", 8'h01, {7'h00, irq});
    wr_reg(T3_CTRL_OFS, 8'h0c);
    repeat (3) @(negedge clk);
    rd_reg(T3_CTRL_OFS, r1);
    chk("high flag", 8'h80, r1 & 8'h80);
    wr_reg(T3_CTRL_OFS, 8'h08);
    rd_reg(T3_CNTH_OFS, r1);
    chk_rng("high reload", 8'h12, 8'h20, r1);
    $display("test split mode done");
    {hsel, lsel} = 2'b00;
    for (int c = 0; c < 4; c++)
    begin
      // Source first, then the counts, so no tick of the old source slips in.
      wr_reg(T3_CTRL_OFS, 8'h0c | 8'(c));
      wr_reg(T3_CNTL_OFS, 8'h00);
      wr_reg(T3_CNTH_OFS, 8'h00);
      for (int i = 0; i < 120; i++)
      begin
        @(negedge clk);
        osc = i[2];
        cmp = i[4];
      end
      rd_reg(T3_CNTL_OFS, r1);
      rd_reg(T3_CNTH_OFS, r2);
      lo_e = c[0] ? 8'(1 + 2 * c[1]) : 8'h09;
      hi_e = c[0] ? 8'(2 + 2 * c[1]) : 8'h0b;
      chk_rng("source count", lo_e, hi_e, r1);
      chk_rng("high source count", lo_e, hi_e, r2);
    end
    $display("test clock sources done");
    lsel = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(T3_CNTL_OFS, 8'h00);
      wr_reg(T3_CNTH_OFS, 8'h00);
      wr_reg(T3_CTRL_OFS, 8'h14 | 8'(c));
      for (int i = 0; i < 100; i++)
      begin
        @(negedge clk);
        if (i == 51)
          r1 = rdata;
        if (i == (c[1] ? 83 : 91))
          r2 = rdata;
        rd = (i == 50 || i == (c[1] ? 82 : 90));
        addr = T3_RLL_OFS;
        cmp = (i % 40) >= 20;
        osc = (i % 4) >= 2;
      end
      chk("capture period", c[1] ? 8'd32 : 8'd40, r2 - r1);
      rd_chk("capture flag", T3_CTRL_OFS, 8'h94 | 8'(c));
      wr_reg(T3_CTRL_OFS, 8'h00);
    end
    $display("test capture done");
    end_of_test();
  end
endmodule
bind t3_timer t3_timer_asserts chk_u (.clk(clk), .rstn(rstn),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer_irq(timer_irq),
  .timer_irq_global_enable(timer_irq_global_enable));
`default_nettype wire
